/* i2c_slave_tx.sv */
// i2c slave transmitter and master-mode event flags of the sync serial port
// assumes SCL/SDA arrive asynchronously; software ports are on MCLK
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.svh"
module i2c_slave_tx #(
  parameter int BUF_DEPTH = `BUF_DEPTH
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic PORT_ENABLE,
  input wire logic MODE_I2C,
  input wire logic MASTER_MODE,
  input wire logic [6:0] SLAVE_ADDR,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_WRITE,
  input wire logic CTRL_WRITE,
  input wire logic [7:0] CTRL_DATA,
  input wire logic IRQ_CLEAR,
  input wire logic IRQ_ENABLE,
  input wire logic M_START_EV,
  input wire logic M_BYTE_EV,
  input wire logic M_ACK_EV,
  input wire logic M_SCL_DRIVE_LOW,
  input wire logic M_SDA_DRIVE_LOW,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic TX_READY,
  output logic [7:0] SERIAL_BUFFER,
  output logic READ_FLAG,
  output logic START_SEEN,
  output logic STOP_SEEN,
  output logic BUS_FREE,
  output logic CLOCK_RELEASE,
  output logic PORT_IRQ_FLAG,
  output logic PORT_IRQ,
  output logic NACK_SEEN
);
  logic [1:0] pins;
  logic scl_q_reg, sda_q_reg;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  logic i2c_on;
  ssp_pkg::slave_state_e state_reg;
  ssp_pkg::byte_t serial_shift_reg;
  ssp_pkg::byte_t serial_buffer_reg;
  logic [3:0] bit_cnt_reg;
  logic sda_low_reg, scl_hold_reg;
  logic release_hit, tx_take;
  logic ninth_reg;
  byte_stream_if wr_s ();
  byte_stream_if rd_s ();

  // bus pins reach logic only through two flops
  pin_sync #(.W(2)) u_sync (
    .clk(MCLK),
    .rst(RST),
    .d({SCL_IN, SDA_IN}),
    .q(pins)
  );

  // exactly one serial mode at a time; spi logic lives elsewhere
  assign i2c_on = PORT_ENABLE && (MODE_I2C == 1'(ssp_pkg::MODE_I2C));

  always_ff @(posedge MCLK) begin
    if (RST) begin
      scl_q_reg <= 1'h1;
      sda_q_reg <= 1'h1;
    end else begin
      scl_q_reg <= pins[1];
      sda_q_reg <= pins[0];
    end
  end
  assign scl_rise = pins[1] && !scl_q_reg;
  assign scl_fall = !pins[1] && scl_q_reg;
  assign start_ev = pins[1] && scl_q_reg && sda_q_reg && !pins[0];
  assign stop_ev = pins[1] && scl_q_reg && !sda_q_reg && pins[0];

  // software writes go through the buffer; full shows as not ready
  assign wr_s.valid = TX_WRITE;
  assign wr_s.data = TX_DATA;
  tx_buffer #(.DEPTH(BUF_DEPTH), .W(`BYTE_W)) u_buf (
    .clk(MCLK),
    .rst(RST),
    .in_s(wr_s.snk),
    .out_s(rd_s.src)
  );
  assign release_hit = CTRL_WRITE && CTRL_DATA[`CTRL_RELEASE_BIT];
  assign tx_take = (state_reg == ssp_pkg::ST_STRETCH) && rd_s.valid && CLOCK_RELEASE;
  assign rd_s.ready = tx_take;

  // slave sequencer
  always_ff @(posedge MCLK) begin
    if (RST || !i2c_on || MASTER_MODE) begin
      state_reg <= ssp_pkg::ST_IDLE;
      bit_cnt_reg <= 4'h0;
      serial_shift_reg <= 8'h00;
      sda_low_reg <= 1'h0;
      scl_hold_reg <= 1'h0;
      NACK_SEEN <= 1'h0;
    end else if (start_ev) begin
      NACK_SEEN <= 1'h0;
      state_reg <= ssp_pkg::ST_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_low_reg <= 1'h0;
      scl_hold_reg <= 1'h0;
    end else if (stop_ev) begin
      NACK_SEEN <= 1'h0;
      state_reg <= ssp_pkg::ST_IDLE;
      sda_low_reg <= 1'h0;
      scl_hold_reg <= 1'h0;
    end else begin
      NACK_SEEN <= 1'h0;
      case (state_reg)
        ssp_pkg::ST_IDLE: begin
          bit_cnt_reg <= 4'h0;
        end
        ssp_pkg::ST_ADDR: begin
          if (scl_rise) begin
            serial_shift_reg <= {serial_shift_reg[6:0], pins[0]};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == `BITS_PER_BYTE) begin
            // only a read request to our address is answered
            if (serial_shift_reg[7:1] == SLAVE_ADDR && serial_shift_reg[0]) begin
              sda_low_reg <= 1'h1;
              state_reg <= ssp_pkg::ST_ADDR_ACK;
            end else begin
              state_reg <= ssp_pkg::ST_IDLE;
            end
          end
        end
        ssp_pkg::ST_ADDR_ACK: begin
          // ack held through the ninth pulse, then clock stretched
          if (scl_fall) begin
            sda_low_reg <= 1'h0;
            scl_hold_reg <= 1'h1;
            state_reg <= ssp_pkg::ST_STRETCH;
          end
        end
        ssp_pkg::ST_STRETCH: begin
          // data load plus release must both happen before clocking resumes
          if (tx_take) begin
            serial_shift_reg <= rd_s.data;
            sda_low_reg <= !rd_s.data[7];
            bit_cnt_reg <= 4'h1;
            scl_hold_reg <= 1'h0;
            state_reg <= ssp_pkg::ST_SHIFT;
          end
        end
        ssp_pkg::ST_SHIFT: begin
          // change sda only after scl falls so it is steady while high
          if (scl_fall) begin
            if (bit_cnt_reg == `BITS_PER_BYTE) begin
              sda_low_reg <= 1'h0;
              state_reg <= ssp_pkg::ST_MACK;
            end else begin
              serial_shift_reg <= {serial_shift_reg[6:0], 1'h0};
              sda_low_reg <= !serial_shift_reg[6];
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        ssp_pkg::ST_MACK: begin
          if (scl_rise) begin
            if (pins[0]) begin
              NACK_SEEN <= 1'h1;
              state_reg <= ssp_pkg::ST_IDLE;
            end else begin
              bit_cnt_reg <= `ACK_BIT_IDX;
            end
          end else if (scl_fall && bit_cnt_reg == `ACK_BIT_IDX) begin
            scl_hold_reg <= 1'h1;
            state_reg <= ssp_pkg::ST_STRETCH;
          end
        end
        default: begin
          state_reg <= ssp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // received address, read/write status and each byte taken for sending, for software
  always_ff @(posedge MCLK) begin
    if (RST) begin
      serial_buffer_reg <= 8'h00;
      READ_FLAG <= 1'h0;
    end else if (state_reg == ssp_pkg::ST_ADDR && scl_fall && bit_cnt_reg == `BITS_PER_BYTE
                 && serial_shift_reg[7:1] == SLAVE_ADDR) begin
      serial_buffer_reg <= serial_shift_reg;
      READ_FLAG <= serial_shift_reg[0];
    end else if (tx_take) begin
      serial_buffer_reg <= rd_s.data;
    end
  end
  assign SERIAL_BUFFER = serial_buffer_reg;

  // release bit: software sets it, hardware clears it when the byte is taken and stretching ends
  always_ff @(posedge MCLK) begin
    if (RST || !i2c_on) begin
      CLOCK_RELEASE <= 1'h0;
    end else if (release_hit) begin
      CLOCK_RELEASE <= 1'h1;
    end else if (tx_take) begin
      CLOCK_RELEASE <= 1'h0;
    end
  end

  // start/stop seen flags; disabling the port wipes them
  always_ff @(posedge MCLK) begin
    if (RST || !i2c_on) begin
      START_SEEN <= 1'h0;
      STOP_SEEN <= 1'h0;
    end else if (start_ev) begin
      START_SEEN <= 1'h1;
      STOP_SEEN <= 1'h0;
    end else if (stop_ev) begin
      START_SEEN <= 1'h0;
      STOP_SEEN <= 1'h1;
    end
  end

  // bus available to a master after stop, or when never used
  always_ff @(posedge MCLK) begin
    if (RST) begin
      BUS_FREE <= 1'h0;
    end else begin
      BUS_FREE <= i2c_on && (STOP_SEEN || (!START_SEEN && !STOP_SEEN));
    end
  end

  // ninth pulse seen high; kept apart from the sequencer because a nack
  // sends the sequencer to idle before the ninth falling edge arrives
  always_ff @(posedge MCLK) begin
    if (RST || !i2c_on || MASTER_MODE) begin
      ninth_reg <= 1'h0;
    end else if (state_reg == ssp_pkg::ST_MACK && scl_rise) begin
      ninth_reg <= 1'h1;
    end else if (scl_fall || start_ev || stop_ev) begin
      ninth_reg <= 1'h0;
    end
  end

  // irq flag: hardware set beats software clear in the same cycle
  always_ff @(posedge MCLK) begin
    if (RST) begin
      PORT_IRQ_FLAG <= 1'h0;
    end else if ((state_reg == ssp_pkg::ST_ADDR_ACK && scl_fall)
                 || (ninth_reg && scl_fall)) begin
      PORT_IRQ_FLAG <= 1'h1;
    end else if (i2c_on && MASTER_MODE
                 && (M_START_EV || stop_ev || M_BYTE_EV || M_ACK_EV)) begin
      PORT_IRQ_FLAG <= 1'h1;
    end else if (IRQ_CLEAR) begin
      PORT_IRQ_FLAG <= 1'h0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      PORT_IRQ <= 1'h0;
    end else begin
      PORT_IRQ <= PORT_IRQ_FLAG && IRQ_ENABLE;
    end
  end

  // pin drivers; master mode hands the lines to the sequencer inputs
  always_ff @(posedge MCLK) begin
    if (RST || !i2c_on) begin
      SCL_OE <= 1'h0;
      SDA_OE <= 1'h0;
    end else if (MASTER_MODE) begin
      SCL_OE <= M_SCL_DRIVE_LOW;
      SDA_OE <= M_SDA_DRIVE_LOW;
    end else begin
      SCL_OE <= scl_hold_reg;
      SDA_OE <= sda_low_reg;
    end
  end
  always_ff @(posedge MCLK) begin
    if (RST) begin
      SCL_OUT <= 1'h0;
      SDA_OUT <= 1'h0;
      TX_READY <= 1'h0;
    end else begin
      SCL_OUT <= 1'h0;
      SDA_OUT <= 1'h0;
      TX_READY <= wr_s.ready;
    end
  end

  // stretching holds scl low while release is still clear
  chk_stretch_hold: assert property (@(posedge MCLK) disable iff (RST)
    (state_reg == ssp_pkg::ST_STRETCH && !CLOCK_RELEASE && !MASTER_MODE && i2c_on)
    |=> SCL_OE) else $error("scl not held during stretch");
  chk_flag_clear: assert property (@(posedge MCLK) disable iff (RST)
    !i2c_on |=> !START_SEEN && !STOP_SEEN) else $error("start/stop not cleared");
  chk_irq_gate: assert property (@(posedge MCLK) disable iff (RST)
    PORT_IRQ |-> $past(PORT_IRQ_FLAG) && $past(IRQ_ENABLE)) else $error("irq ungated");
  chk_nack_idle: assert property (@(posedge MCLK) disable iff (RST)
    NACK_SEEN |-> state_reg == ssp_pkg::ST_IDLE) else $error("nack not idle");
  chk_bus_free: assert property (@(posedge MCLK) disable iff (RST)
    BUS_FREE |-> $past(STOP_SEEN) || !$past(START_SEEN)) else $error("bus taken busy");
  chk_irq_sticky: assert property (@(posedge MCLK) disable iff (RST)
    PORT_IRQ_FLAG && !IRQ_CLEAR |=> PORT_IRQ_FLAG) else $error("irq flag lost");
  chk_release_set: assert property (@(posedge MCLK) disable iff (RST)
    i2c_on && release_hit |=> CLOCK_RELEASE) else $error("release not set");
  chk_sda_steady: assert property (@(posedge MCLK) disable iff (RST)
    state_reg == ssp_pkg::ST_SHIFT && scl_rise |=> $stable(sda_low_reg))
    else $error("sda moved on rise");
  chk_ninth_irq: assert property (@(posedge MCLK) disable iff (RST)
    ninth_reg && scl_fall |=> PORT_IRQ_FLAG) else $error("ninth fall left irq clear");

  // address acknowledged, then the ninth falling edge flags and stretches
  sequence seq_addr_ninth_fall;
    state_reg == ssp_pkg::ST_ADDR_ACK && scl_fall && i2c_on && !MASTER_MODE;
  endsequence
  sequence seq_flag_and_hold;
    PORT_IRQ_FLAG && scl_hold_reg;
  endsequence
  chk_ack_stretch_irq: assert property (@(posedge MCLK) disable iff (RST)
    seq_addr_ninth_fall |=> seq_flag_and_hold) else $error("no stretch after address ack");

  // master leaves sda high on the ninth rise: slave logic drops to idle
  sequence seq_nack_rise;
    state_reg == ssp_pkg::ST_MACK && scl_rise && pins[0] && i2c_on && !MASTER_MODE;
  endsequence
  chk_nack_release: assert property (@(posedge MCLK) disable iff (RST)
    seq_nack_rise |=> NACK_SEEN && state_reg == ssp_pkg::ST_IDLE && !sda_low_reg)
    else $error("nack did not end the transfer");
endmodule
`default_nettype wire

/* ssp_defines.svh */
// shared constants for the sync serial port i2c block
// assumes inclusion by bare name from design files
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH
`define CLK_PERIOD_NS 8
`define CTRL_RELEASE_BIT 4
`define ADDR_W 7
`define BYTE_W 8
`define BITS_PER_BYTE 4'h8
`define ACK_BIT_IDX 4'h8
`define BUF_DEPTH 2
`endif

/* ssp_pkg.sv */
// types for the sync serial port i2c block
// assumes the defines header is compiled alongside
package ssp_pkg;
  typedef enum logic {MODE_SPI, MODE_I2C} port_mode_e;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_STRETCH, ST_SHIFT,
    ST_MACK} slave_state_e;
  typedef logic [7:0] byte_t;
endpackage

/* byte_stream_if.sv */
// valid/ready byte carrier between the port's internal modules
// assumes both ends share one clock
`timescale 1ns/1ps
`default_nettype none
interface byte_stream_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* pin_sync.sv */
// two-flop synchroniser for pins arriving from the bus
// assumes async inputs; only the second flop is read
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  // first flop feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '1;
      q <= '1;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

/* tx_buffer.sv */
// two-entry buffer for transmit bytes written by software
// assumes source and sink on the same clock
`timescale 1ns/1ps
`default_nettype none
module tx_buffer #(
  parameter int DEPTH = 2,
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  byte_stream_if.snk in_s,
  byte_stream_if.src out_s
);
  logic [W-1:0] mem_reg [DEPTH];
  logic [0:0] wr_reg, rd_reg;
  logic [1:0] cnt_reg;
  logic push, pop;
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;
  // full stalls the writer, empty stalls the reader
  assign in_s.ready = (cnt_reg != 2'(DEPTH));
  assign out_s.valid = (cnt_reg != 2'h0);
  assign out_s.data = mem_reg[rd_reg];
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_s.data;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_reg <= 1'h0;
      rd_reg <= 1'h0;
      cnt_reg <= 2'h0;
    end else begin
      if (push) begin
        wr_reg <= ~wr_reg;
      end
      if (pop) begin
        rd_reg <= ~rd_reg;
      end
      cnt_reg <= cnt_reg + {1'h0, push} - {1'h0, pop};
    end
  end
endmodule
`default_nettype wire

/* i2c_master_model.sv */
// behavioural i2c bus master that reads from the port as slave transmitter
// assumes the bench resolves open-drain wires with pull-ups and feeds them back
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_low,
  output logic sda_low
);
  event got;
  logic [7:0] rx_byte;
  logic s;

  // both lines released while no frame runs, so the link clock stands still
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // one 80 ns bit cell; sda only moves while scl is low
  task automatic clk_bit(input logic drive, input logic val, output logic smp);
    sda_low = drive & ~val;
    #20;
    scl_low = 1'b0;
    wait (scl_in === 1'b1);
    #20;
    smp = sda_in;
    #20;
    scl_low = 1'b1;
    #20;
  endtask

  task automatic start();
    sda_low = 1'b1;
    #40;
    scl_low = 1'b1;
    #20;
  endtask

  task automatic stop();
    sda_low = 1'b1;
    #20;
    scl_low = 1'b0;
    wait (scl_in === 1'b1);
    #20;
    sda_low = 1'b0;
    #40;
  endtask

  // msb first, then the slave's acknowledge level
  task automatic write_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i], s);
    clk_bit(1'b0, 1'b0, ack);
  endtask

  // released sda while reading; ack level driven on the ninth cell
  task automatic read_byte(input logic ack);
    for (int i = 7; i >= 0; i--) clk_bit(1'b0, 1'b0, rx_byte[i]);
    clk_bit(1'b1, ack, s);
    -> got;
  endtask
endmodule
`default_nettype wire

/* tb_i2c_slave_tx_and_master_events.sv */
// bench for the i2c slave transmitter and master-mode event flags
// assumes a 125 MHz MCLK and pull-ups on both bus wires, resolved here
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_slave_tx_and_master_events;
  logic MCLK, RST, PORT_ENABLE, MODE_I2C, MASTER_MODE, TX_WRITE, CTRL_WRITE, IRQ_CLEAR;
  logic IRQ_ENABLE, M_START_EV, M_BYTE_EV, M_ACK_EV, M_SCL_DRIVE_LOW, M_SDA_DRIVE_LOW;
  logic SCL_OUT, SCL_OE, SDA_OUT, SDA_OE, TX_READY, READ_FLAG, START_SEEN, STOP_SEEN;
  logic BUS_FREE, CLOCK_RELEASE, PORT_IRQ_FLAG, PORT_IRQ, NACK_SEEN, m_scl_low, m_sda_low;
  logic rd_phase, a;
  logic [6:0] SLAVE_ADDR;
  logic [7:0] TX_DATA, CTRL_DATA, SERIAL_BUFFER, b;
  logic [7:0] exp_q[$];
  int seed = 5;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  int nack_cnt = 0;
  int n;
  wire scl_w;
  wire sda_w;

  // open-drain wires: any pull wins, pull-up otherwise
  assign scl_w = ~(SCL_OE | m_scl_low);
  assign sda_w = ~(SDA_OE | m_sda_low);

  i2c_slave_tx dut (.MCLK(MCLK), .RST(RST), .PORT_ENABLE(PORT_ENABLE), .MODE_I2C(MODE_I2C),
    .MASTER_MODE(MASTER_MODE), .SLAVE_ADDR(SLAVE_ADDR), .TX_DATA(TX_DATA),
    .TX_WRITE(TX_WRITE), .CTRL_WRITE(CTRL_WRITE), .CTRL_DATA(CTRL_DATA),
    .IRQ_CLEAR(IRQ_CLEAR), .IRQ_ENABLE(IRQ_ENABLE), .M_START_EV(M_START_EV),
    .M_BYTE_EV(M_BYTE_EV), .M_ACK_EV(M_ACK_EV), .M_SCL_DRIVE_LOW(M_SCL_DRIVE_LOW),
    .M_SDA_DRIVE_LOW(M_SDA_DRIVE_LOW), .SCL_IN(scl_w), .SDA_IN(sda_w), .SCL_OUT(SCL_OUT),
    .SCL_OE(SCL_OE), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .TX_READY(TX_READY),
    .SERIAL_BUFFER(SERIAL_BUFFER), .READ_FLAG(READ_FLAG), .START_SEEN(START_SEEN),
    .STOP_SEEN(STOP_SEEN), .BUS_FREE(BUS_FREE), .CLOCK_RELEASE(CLOCK_RELEASE),
    .PORT_IRQ_FLAG(PORT_IRQ_FLAG), .PORT_IRQ(PORT_IRQ), .NACK_SEEN(NACK_SEEN));

  i2c_master_model m (.scl_in(scl_w), .sda_in(sda_w), .scl_low(m_scl_low),
    .sda_low(m_sda_low));

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // software inputs always move 1 ns after the rising edge
  task automatic cyc(input int k);
    repeat (k) @(posedge MCLK);
    #1;
  endtask

  task automatic tx_put(input logic [7:0] d);
    TX_DATA = d;
    TX_WRITE = 1'b1;
    cyc(1);
    TX_WRITE = 1'b0;
    cyc(1);
  endtask

  task automatic rel();
    CTRL_DATA = 8'h10;
    CTRL_WRITE = 1'b1;
    cyc(1);
    CTRL_WRITE = 1'b0;
    cyc(1);
  endtask

  task automatic clr();
    IRQ_CLEAR = 1'b1;
    cyc(1);
    IRQ_CLEAR = 1'b0;
    cyc(1);
  endtask

  task automatic ev(input int k);
    {M_START_EV, M_BYTE_EV, M_ACK_EV} = 3'(3'h4 >> k);
    cyc(1);
    {M_START_EV, M_BYTE_EV, M_ACK_EV} = 3'h0;
    cyc(3);
  endtask

  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end

  // hang guard, far above the several hundred cycles the run needs
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  always @(posedge MCLK) if (NACK_SEEN === 1'b1) nack_cnt++;

  // data bits must not move while scl is high
  always @(sda_w) if (rd_phase && scl_w === 1'b1) chk({7'h0, sda_w}, {7'h0, ~sda_w});

  // each byte the master receives is matched to the oldest written byte
  always @(m.got) begin
    if (exp_q.size() == 0) chk(m.rx_byte, ~m.rx_byte);
    else chk(m.rx_byte, exp_q.pop_front());
  end

  initial begin
    {RST, PORT_ENABLE, MODE_I2C} = 3'h7;
    {MASTER_MODE, TX_WRITE, CTRL_WRITE, IRQ_CLEAR, IRQ_ENABLE, rd_phase} = 6'h00;
    {M_START_EV, M_BYTE_EV, M_ACK_EV, M_SCL_DRIVE_LOW, M_SDA_DRIVE_LOW} = 5'h00;
    TX_DATA = 8'h00;
    CTRL_DATA = 8'h00;
    SLAVE_ADDR = 7'($random(seed));
    cyc(6);
    RST = 1'b0;
    cyc(1);
    chk({4'h0, START_SEEN, STOP_SEEN, SCL_OE, SDA_OE}, 8'h00);
    // wrong address, write request, spi mode: none may answer
    for (int i = 0; i < 3; i++) begin
      MODE_I2C = (i != 2);
      m.start();
      m.write_byte({SLAVE_ADDR ^ 7'(i == 0), 1'(i != 1)}, a);
      cyc(4);
      chk({6'h0, a, READ_FLAG}, 8'h02);
      m.stop();
      cyc(2);
    end
    MODE_I2C = 1'b1;
    m.start();
    cyc(4);
    chk({7'h0, START_SEEN}, 8'h01);
    m.write_byte({SLAVE_ADDR, 1'b1}, a);
    cyc(6);
    chk({4'h0, a, READ_FLAG, SCL_OE, PORT_IRQ_FLAG}, 8'h07);
    chk(SERIAL_BUFFER, {SLAVE_ADDR, 1'b1});
    chk({7'h0, PORT_IRQ}, 8'h00);
    clr();
    chk({7'h0, PORT_IRQ_FLAG}, 8'h00);
    // fill the buffer until refused, clock still held
    n = 0;
    while (TX_READY === 1'b1 && n < 4) begin
      b = 8'($random(seed));
      tx_put(b);
      exp_q.push_back(b);
      n++;
    end
    tx_put(8'h5a);
    chk({6'h0, TX_READY, SCL_OE}, 8'h01);
    for (int k = 0; k < n; k++) begin
      rel();
      rd_phase = 1'b1;
      m.read_byte(k == n - 1);
      rd_phase = 1'b0;
      cyc(6);
      chk({6'h0, SCL_OE, PORT_IRQ_FLAG}, {6'h0, 1'(k < n - 1), 1'b1});
      clr();
    end
    chk({5'h0, CLOCK_RELEASE, SCL_OE, SDA_OE}, 8'h00);
    chk(8'(nack_cnt), 8'h01);
    m.stop();
    cyc(4);
    chk({6'h0, STOP_SEEN, BUS_FREE}, 8'h03);
    PORT_ENABLE = 1'b0;
    cyc(4);
    chk({6'h0, START_SEEN, STOP_SEEN}, 8'h00);
    PORT_ENABLE = 1'b1;
    MASTER_MODE = 1'b1;
    IRQ_ENABLE = 1'b1;
    for (int k = 0; k < 3; k++) begin
      ev(k);
      chk({6'h0, PORT_IRQ_FLAG, PORT_IRQ}, 8'h03);
      clr();
    end
    m.start();
    cyc(4);
    clr();
    m.stop();
    cyc(4);
    chk({7'h0, PORT_IRQ_FLAG}, 8'h01);
    clr();
    IRQ_ENABLE = 1'b0;
    ev(1);
    chk({6'h0, PORT_IRQ_FLAG, PORT_IRQ}, 8'h02);
    {M_SCL_DRIVE_LOW, M_SDA_DRIVE_LOW} = 2'h3;
    cyc(3);
    chk({4'h0, SCL_OUT, SDA_OUT, SCL_OE, SDA_OE}, 8'h03);
    {M_SCL_DRIVE_LOW, M_SDA_DRIVE_LOW} = 2'h0;
    cyc(3);
    chk({6'h0, SCL_OE, SDA_OE}, 8'h00);
    rel();
    chk({5'h0, CLOCK_RELEASE, SCL_OUT, SDA_OUT}, 8'h04);
    wrap_up();
  end
endmodule
`default_nettype wire
